// >>> bench/sre_core_props.sv
// pin-level assertions for the serial memory slave
// assumes binding onto sre_core with its write-cycle parameter
`timescale 1ns/1ps
`default_nettype none
module sre_core_props #(
    parameter int WRITE_CYCLES_P = 1000
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic busy
);
    logic [19:0] cnt_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    always_ff @(posedge clk_sys) begin
        if (srst || !busy) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 20'h1;
        end
    end
    sequence s_bus_idle;
        scl_in && sda_in;
    endsequence
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    a_reset_quiet: assert property ($past(srst) |-> !sda_oe && !busy)
        else $error("outputs active after reset");
    a_open_drain: assert property (!sda_o)
        else $error("data drive value not low");
    a_busy_mute: assert property (busy |-> !sda_oe)
        else $error("line pulled during write cycle");
    a_busy_length: assert property ($fell(busy) && !$past(srst) |-> cnt_q == WRITE_CYCLES_P)
        else $error("write cycle length wrong");
    a_busy_min: assert property ($rose(busy) |=> busy[*8])
        else $error("write cycle too short");
    a_busy_on_stop: assert property ($rose(busy) |-> s_bus_idle)
        else $error("write cycle began off a stop");
    a_change_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data line changed near clock high");
    a_start_free: assert property (s_start |-> !sda_oe)
        else $error("device holds line at start");
endmodule
bind sre_core sre_core_props #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_props (
    .clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
`default_nettype wire

// >>> bench/sre_core_test.sv
// self-checking bench for the serial memory read and busy-poll slave
// assumes the master model in sre_master and the bound checker
`timescale 1ns/1ps
`default_nettype none
module sre_core_test;
    import sre_pkg::*;
    localparam logic [2:0] CS = 3'h5;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [2:0] cs_pins = CS;
    logic sda_o, sda_oe, busy, scl, nak;
    logic [7:0] q;
    wire logic sda;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    always #2.5 clk_sys = !clk_sys;
    sre_core #(.WRITE_CYCLES_P(400)) uut (.clk_sys(clk_sys), .srst(srst),
        .scl_in(scl), .sda_in(sda), .chip_select_bit_two(cs_pins[2]),
        .chip_select_bit_one(cs_pins[1]), .chip_select_bit_zero(cs_pins[0]),
        .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
    sre_master m (.clk_sys(clk_sys), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic ctrl(input logic rw);
        m.start();
        m.xbyte({DEV_TYPE_CODE, CS, rw}, 1'b0, q, nak);
    endtask
    task automatic set_addr(input logic [15:0] a);
        ctrl(1'b0);
        m.xbyte(a[15:8], 1'b0, q, nak);
        m.xbyte(a[7:0], 1'b0, q, nak);
    endtask
    task automatic get(input logic mack, input logic [7:0] exp);
        m.xbyte(8'hFF, mack, q, nak);
        check(q, exp);
    endtask
    // write one byte, then poll until acknowledged
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        int n;
        set_addr(a);
        m.xbyte(d, 1'b0, q, nak);
        m.stop();
        check(busy, 1'b1);
        n = 0;
        do begin
            ctrl(1'b0);
            n++;
        end while (nak === 1'b1 && n < 20);
        check(n > 1, 1'b1);
        check(nak, 1'b0);
        m.stop();
    endtask
    task automatic t_write();
        put(16'hFFFF, 8'h5A);
        put(16'h0000, 8'hC3);
        put(16'h0001, 8'h96);
        $display("write and poll test done");
    endtask
    task automatic t_read();
        set_addr(16'h7FFF);
        ctrl(1'b1);
        check(nak, 1'b0);
        get(1'b0, 8'h5A);
        m.stop();
        check(busy, 1'b0);
        ctrl(1'b1);
        check(nak, 1'b0);
        get(1'b1, 8'hC3);
        get(1'b0, 8'h96);
        m.stop();
        $display("random and current read test done");
    endtask
    task automatic t_wrap();
        set_addr(16'h7FFF);
        ctrl(1'b1);
        get(1'b1, 8'h5A);
        get(1'b0, 8'hC3);
        m.stop();
        $display("wrap test done");
    endtask
    task automatic t_mismatch();
        m.start();
        m.xbyte({4'h5, CS, 1'b1}, 1'b0, q, nak);
        check(nak, 1'b1);
        m.start();
        m.xbyte({DEV_TYPE_CODE, CS ^ 3'h1, 1'b0}, 1'b0, q, nak);
        check(nak, 1'b1);
        m.stop();
        check(sda_oe, 1'b0);
        cs_pins <= CS ^ 3'h4;
        ctrl(1'b0);
        check(nak, 1'b1);
        cs_pins <= CS;
        ctrl(1'b0);
        check(nak, 1'b0);
        m.stop();
        check(sda_o, 1'b0);
        $display("mismatch test done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_write();
        t_read();
        t_wrap();
        t_mismatch();
        give_verdict();
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
endmodule
`default_nettype wire

// >>> bench/sre_master.sv
// two-wire bus master model: start, stop and byte transfers
// assumes the device pulls sda low through dev_oe; line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module sre_master (
    input wire logic clk_sys,
    input wire logic dev_oe,
    output logic scl,
    output wire logic sda
);
    logic m_oe = 1'b0;
    initial scl = 1'b1;
    assign sda = !(m_oe | dev_oe);
    task automatic hp();
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic start();
        m_oe <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        m_oe <= 1'b1;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop();
        m_oe <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        m_oe <= 1'b0;
        hp();
    endtask
    // one bit takes 13 clocks, the nearest whole count to the 64 ns bus clock
    task automatic xbit(input logic b, output logic r);
        m_oe <= !b;
        repeat (4) @(posedge clk_sys);
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // msb first, ninth bit is the acknowledge
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(!mack, nak);
    endtask
endmodule
`default_nettype wire

// >>> hw/sre_core.sv
// two-wire serial memory slave: control byte match, address pointer,
// current, random and sequential reads, busy polling during the write cycle
// assumes scl and sda arrive from pins asynchronously; sda is open drain
//
// Function
// - while write cycle runs, never acknowledge any received byte.
// - stop ending a write command starts the timed write cycle.
// - after write cycle ends, polled control byte is acknowledged.
// - address counter holds last accessed location plus one, rolling over within the 64-byte page after a write.
// - current read: ack control, send one byte, master nacks and stops.
// - random read latches word address from write-type sequence, no write.
// - after repeated start, ack read control and send byte at address.
// - after random read, pointer sits at byte after the one returned.
// - master ack after a byte makes the device send the next byte.
// - pointer increments by one after each byte read; after a write only its low 6 bits increment, wrapping within the page.
// - pointer wraps from top location to zero on acknowledged read.
// - respond only when type code and chip-select bits both match.
// - word address arrives high byte first; upper unused bit ignored.
`timescale 1ns/1ps
`default_nettype none
module sre_core #(
    parameter int WRITE_CYCLES_P = sre_pkg::WRITE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic chip_select_bit_two,
    input wire logic chip_select_bit_one,
    input wire logic chip_select_bit_zero,
    output logic sda_o,
    output logic sda_oe,
    output logic busy
);
    import sre_pkg::*;

    sre_core_t q;
    sre_core_t d;
    logic [7:0] rd_data;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;

    function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
        page_next = {a[ADDR_W-1:6], 6'(a[5:0] + 6'h01)};
    endfunction

    function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] a);
        ptr_next = ADDR_W'(a + 15'h0001);
    endfunction

    sre_mem u_mem (
        .clk_sys(clk_sys),
        .wr(q.wr),
        .rd_addr(q.ptr),
        .rd_data_q(rd_data)
    );

    assign scl = q.scl_s[1];
    assign sda = q.sda_s[1];
    assign rise = scl && !q.scl_p;
    assign fall = !scl && q.scl_p;
    assign start_c = scl && q.scl_p && q.sda_p && !sda;
    assign stop_c = scl && q.scl_p && !q.sda_p && sda;

    always_comb begin
        d = q;
        d.wr.en = 1'b0;
        d.scl_s = {q.scl_s[0], scl_in};
        d.sda_s = {q.sda_s[0], sda_in};
        d.cs_a = {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero};
        d.cs_b = q.cs_a;
        d.scl_p = scl;
        d.sda_p = sda;
        if (q.busy) begin
            if (q.timer <= TIMER_W'(1)) begin
                d.busy = 1'b0;
            end else begin
                d.timer = TIMER_W'(q.timer - 1'b1);
            end
        end
        if (start_c) begin
            d.state = ST_RX;
            d.kind = BY_CTRL;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.state = ST_IDLE;
            d.sda_oe = 1'b0;
            if (q.wr_pend) begin
                d.busy = 1'b1;
                d.timer = TIMER_W'(WRITE_CYCLES_P);
                d.wr_pend = 1'b0;
            end
        end else begin
            case (q.state)
                ST_RX: begin
                    if (rise && q.cnt != BITS_PER_BYTE) begin
                        d.sh = {q.sh[6:0], sda};
                        d.cnt = 4'(q.cnt + 1'b1);
                    end else if (fall && q.cnt == BITS_PER_BYTE) begin
                        d.state = ST_ACK;
                        d.sda_oe = 1'b1;
                        case (q.kind)
                            BY_CTRL: begin
                                d.rw = q.sh[0];
                                if (q.sh[7:4] != DEV_TYPE_CODE || q.sh[3:1] != q.cs_b
                                        || q.busy) begin
                                    d.state = ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end else begin
                                    d.kind = BY_AHI;
                                end
                            end
                            BY_AHI: begin
                                // high byte first, top bit dropped
                                d.ahi = q.sh[6:0];
                                d.kind = BY_ALO;
                            end
                            BY_ALO: begin
                                d.ptr = {q.ahi, q.sh};
                                d.kind = BY_DATA;
                            end
                            default: begin
                                d.wr.en = 1'b1;
                                d.wr.addr = q.ptr;
                                d.wr.data = q.sh;
                                d.ptr = page_next(q.ptr);
                                d.wr_pend = 1'b1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (fall) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            d.state = ST_TX;
                            d.sh = rd_data;
                            d.sda_oe = !rd_data[7];
                            d.ptr = ptr_next(q.ptr);
                        end else begin
                            d.state = ST_RX;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (fall) begin
                        if (q.cnt == BIT_LAST) begin
                            d.state = ST_MACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_oe = !q.sh[6];
                            d.cnt = 4'(q.cnt + 1'b1);
                        end
                    end
                end
                ST_MACK: begin
                    if (rise) begin
                        d.rw = !sda;
                    end else if (fall) begin
                        if (q.rw) begin
                            d.state = ST_TX;
                            d.cnt = 4'h0;
                            d.sh = rd_data;
                            d.sda_oe = !rd_data[7];
                            d.ptr = ptr_next(q.ptr);
                        end else begin
                            d.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        if (srst) begin
            d = '0;
            d.state = ST_IDLE;
            d.kind = BY_CTRL;
            d.ptr = PTR_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign sda_o = q.sda_o;
    assign sda_oe = q.sda_oe;
    assign busy = q.busy;
endmodule
`default_nettype wire

// >>> hw/sre_mem.sv
// byte array of the serial memory, flip-flop storage
// assumes one write port and a registered read on the same clock
`timescale 1ns/1ps
`default_nettype none
module sre_mem (
    input wire logic clk_sys,
    input wire sre_pkg::sre_wr_t wr,
    input wire logic [sre_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data_q
);
    import sre_pkg::*;

    logic [7:0] mem_q [MEM_DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr.en) begin
            mem_q[wr.addr] <= wr.data;
        end
        rd_data_q <= mem_q[rd_addr];
    end
endmodule
`default_nettype wire

// >>> include/sre_pkg.sv
// constants and types for the two-wire serial memory read and busy-poll slave
// assumes a single 200 MHz system clock and a synchronous active-high reset
package sre_pkg;
    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam logic [ADDR_W-1:0] PTR_RESET = 15'h0000;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int WRITE_TIME_US = 5;
    localparam int CLK_MHZ = 200;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 20;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} sre_state_t;
    typedef enum logic [1:0] {BY_CTRL, BY_AHI, BY_ALO, BY_DATA} sre_byte_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } sre_wr_t;

    typedef struct packed {
        sre_state_t state;
        sre_byte_t kind;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [6:0] ahi;
        logic [ADDR_W-1:0] ptr;
        logic wr_pend;
        logic [TIMER_W-1:0] timer;
        logic busy;
        logic sda_oe;
        logic sda_o;
        sre_wr_t wr;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        logic [2:0] cs_a;
        logic [2:0] cs_b;
    } sre_core_t;
endpackage
